/* io_space_regs.svh */
// Register offsets, bit masks and decode limits of the low I/O space.
// Assumes inclusion by bare name from each design file that needs them.
`ifndef IO_SPACE_REGS_SVH
`define IO_SPACE_REGS_SVH

// ----------------------------------------------------------------------
// Address limits
// ----------------------------------------------------------------------
`define IO_TOP          6'h3F
`define BIT_TOP         6'h1F
`define DATA_OFFSET     8'h20
`define EXT_BASE        8'h60

// ----------------------------------------------------------------------
// Register offsets (I/O addresses)
// ----------------------------------------------------------------------
`define A_PB_PIN        6'h03
`define A_PB_DIR        6'h04
`define A_PB_OUT        6'h05
`define A_PC_PIN        6'h06
`define A_PC_DIR        6'h07
`define A_PC_OUT        6'h08
`define A_PD_PIN        6'h09
`define A_PD_DIR        6'h0A
`define A_PD_OUT        6'h0B
`define A_PE_PIN        6'h0C
`define A_PE_DIR        6'h0D
`define A_PE_OUT        6'h0E
`define A_T0_FLAGS      6'h15
`define A_T1_FLAGS      6'h16
`define A_SCRATCH1      6'h19
`define A_SCRATCH2      6'h1A
`define A_SCRATCH3      6'h1B
`define A_EXT_FLAGS     6'h1C
`define A_EXT_MASK      6'h1D
`define A_SCRATCH0      6'h1E
`define A_EE_CTRL       6'h1F
`define A_EE_DATA       6'h20
`define A_EE_ADDR_LO    6'h21
`define A_EE_ADDR_HI    6'h22
`define A_TMR_GCTRL     6'h23
`define A_T0_CTRL_A     6'h24
`define A_T0_CTRL_B     6'h25
`define A_T0_COUNT      6'h26
`define A_T0_CMP_A      6'h27
`define A_T0_CMP_B      6'h28
`define A_PLL_CS        6'h29
`define A_SP_CTRL       6'h2C
`define A_SP_STAT       6'h2D
`define A_SP_DATA       6'h2E
`define A_CMP_STAT      6'h30
`define A_SLEEP_CTRL    6'h33
`define A_RST_CAUSE     6'h34
`define A_CORE_CTRL     6'h35
`define A_SELFPROG      6'h37

// ----------------------------------------------------------------------
// Implemented bit masks; reserved bits are zero
// ----------------------------------------------------------------------
`define M_NONE          8'h00
`define M_FULL          8'hFF
`define M_PE            8'h07
`define M_T0_FLAGS      8'h07
`define M_T1_FLAGS      8'h27
`define M_LOW_NIBBLE    8'h0F
`define M_TMR_GCTRL     8'hC1
`define M_T0_CTRL_A     8'hF3
`define M_T0_CTRL_B     8'hCF
`define M_PLL_CS        8'h07
`define M_SP_STAT       8'hC1
`define M_CMP_STAT      8'hF7
`define M_CORE_CTRL     8'h93
`define M_SELFPROG      8'hDF

// ----------------------------------------------------------------------
// Write-one-to-clear flag masks
// ----------------------------------------------------------------------
`define W1C_CMP_STAT    8'h70

`endif

/* io_space_pkg.sv */
// Types shared by the I/O space decoder and its surroundings.
// Assumes the core issues one request at a time and watches BUSY.
package io_space_pkg;

    typedef enum logic [2:0] {
        OP_IO_READ  = 3'h0,
        OP_IO_WRITE = 3'h1,
        OP_BIT_SET  = 3'h2,
        OP_BIT_CLR  = 3'h3,
        OP_BIT_TEST = 3'h4,
        OP_MEM_LOAD = 3'h5,
        OP_MEM_WRITE = 3'h6
    } op_t;

    typedef enum logic [1:0] {
        S_IDLE     = 2'b01,
        S_EXT_WAIT = 2'b10
    } state_t;

    typedef struct packed {
        logic       valid;
        op_t        op;
        logic [7:0] addr;
        logic [2:0] bit_sel;
        logic [7:0] wdata;
    } core_req_t;

    typedef struct packed {
        logic       ack;
        logic [7:0] rdata;
        logic       bit_val;
    } core_rsp_t;

    typedef struct packed {
        logic [7:0] b;
        logic [7:0] c;
        logic [7:0] d;
        logic [7:0] e;
    } pin_level_t;

    typedef struct packed {
        logic [7:0] t0;
        logic [7:0] t1;
        logic [7:0] ei;
        logic [7:0] ac;
    } flag_evt_t;

    typedef struct packed {
        logic       req;
        logic       we;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ext_req_t;

endpackage : io_space_pkg

/* io_space_decode.sv */
// Low I/O register space: port, bit and data-space access decode.
// Assumes a core on CLOCK that holds REQ while BUSY, and extended
// registers outside that answer with EXT_ACK on the same clock.
//
// Overview of operation
// R1 - Software writes zero to reserved bits for forward compatibility.
// R2 - Software never writes reserved I/O addresses.
// R3 - Single-bit set and clear work on I/O addresses up to 0x1F.
// R4 - One selected bit of addresses up to 0x1F is returned for skip tests.
// R5 - Some status flags clear on writing one; writing zero leaves them.
// R6 - A single-bit set or clear touches only the addressed bit.
// R7 - Port instructions decode a 6-bit address, 0x00 to 0x3F.
// R8 - Data-space access sees each register at I/O address plus 0x20.
// R9 - Extended range 0x60 to 0xFF only by data-space load and write.
// R10 - Reserved addresses and bits read zero and ignore writes.
// R11 - A bit operation updates its register in one clock edge.
`timescale 1ns/1ns
`include "io_space_regs.svh"

module io_space_decode (
    input  wire logic                     CLOCK,
    input  wire logic                     RST,
    input  wire io_space_pkg::core_req_t  REQ,
    output logic                          BUSY,
    output io_space_pkg::core_rsp_t       RSP,
    input  wire io_space_pkg::pin_level_t PIN_LEVEL,
    input  wire io_space_pkg::flag_evt_t  FLAG_EVT,
    output io_space_pkg::ext_req_t        EXT_OUT,
    input  wire logic                     EXT_ACK,
    input  wire logic [7:0]               EXT_RDATA,
    output logic [63:0][7:0]              IO_VIEW
);

    // ------------------------------------------------------------------
    // Per-address tables
    // ------------------------------------------------------------------
    function automatic logic [7:0] impl_mask(input logic [5:0] a);
        logic [7:0] m;
        m = `M_NONE;
        if (a == `A_PB_PIN || a == `A_PB_DIR || a == `A_PB_OUT) begin
            m = `M_FULL;
        end else if (a == `A_PC_PIN || a == `A_PC_DIR || a == `A_PC_OUT) begin
            m = `M_FULL;
        end else if (a == `A_PD_PIN || a == `A_PD_DIR || a == `A_PD_OUT) begin
            m = `M_FULL;
        end else if (a == `A_PE_PIN || a == `A_PE_DIR || a == `A_PE_OUT) begin
            m = `M_PE;
        end else if (a == `A_T0_FLAGS) begin
            m = `M_T0_FLAGS;
        end else if (a == `A_T1_FLAGS) begin
            m = `M_T1_FLAGS;
        end else if (a == `A_SCRATCH0 || a == `A_SCRATCH1) begin
            m = `M_FULL;
        end else if (a == `A_SCRATCH2 || a == `A_SCRATCH3) begin
            m = `M_FULL;
        end else if (a == `A_EXT_FLAGS || a == `A_EXT_MASK) begin
            m = `M_LOW_NIBBLE;
        end else if (a == `A_EE_CTRL || a == `A_EE_ADDR_HI) begin
            m = `M_LOW_NIBBLE;
        end else if (a == `A_EE_DATA || a == `A_EE_ADDR_LO) begin
            m = `M_FULL;
        end else if (a == `A_TMR_GCTRL) begin
            m = `M_TMR_GCTRL;
        end else if (a == `A_T0_CTRL_A) begin
            m = `M_T0_CTRL_A;
        end else if (a == `A_T0_CTRL_B) begin
            m = `M_T0_CTRL_B;
        end else if (a == `A_T0_COUNT || a == `A_T0_CMP_A || a == `A_T0_CMP_B) begin
            m = `M_FULL;
        end else if (a == `A_PLL_CS) begin
            m = `M_PLL_CS;
        end else if (a == `A_SP_CTRL || a == `A_SP_DATA) begin
            m = `M_FULL;
        end else if (a == `A_SP_STAT) begin
            m = `M_SP_STAT;
        end else if (a == `A_CMP_STAT) begin
            m = `M_CMP_STAT;
        end else if (a == `A_SLEEP_CTRL || a == `A_RST_CAUSE) begin
            m = `M_LOW_NIBBLE;
        end else if (a == `A_CORE_CTRL) begin
            m = `M_CORE_CTRL;
        end else if (a == `A_SELFPROG) begin
            m = `M_SELFPROG;
        end
        return m;
    endfunction : impl_mask

    function automatic logic is_pin(input logic [5:0] a);
        return a == `A_PB_PIN || a == `A_PC_PIN ||
               a == `A_PD_PIN || a == `A_PE_PIN;
    endfunction : is_pin

    function automatic logic [7:0] w1c_mask(input logic [5:0] a);
        logic [7:0] m;
        m = `M_NONE;
        if (a == `A_T0_FLAGS) begin
            m = `M_T0_FLAGS;
        end else if (a == `A_T1_FLAGS) begin
            m = `M_T1_FLAGS;
        end else if (a == `A_EXT_FLAGS) begin
            m = `M_LOW_NIBBLE;
        end else if (a == `A_CMP_STAT) begin
            m = `W1C_CMP_STAT;
        end
        return m;
    endfunction : w1c_mask

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    io_space_pkg::pin_level_t pin_s1_r;
    io_space_pkg::pin_level_t pin_s2_r;

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
        end else begin
            pin_s1_r <= PIN_LEVEL;
            pin_s2_r <= pin_s1_r;
        end
    end

    // ------------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------------
    io_space_pkg::state_t state_r;
    io_space_pkg::state_t state_nxt;
    logic                 take;
    logic                 port_op;
    logic                 mem_op;
    logic                 bit_op;
    logic                 io_hit;
    logic                 ext_hit;
    logic                 wr_hit;
    logic [5:0]           io_idx;
    logic [7:0]           wen;
    logic [7:0]           wv;
    logic [7:0]           rd_val;
    logic [7:0]           pin_val;
    logic                 bit_ok;
    logic [7:0]           mem_rel;

    always_comb begin
        take    = REQ.valid && (state_r == io_space_pkg::S_IDLE);
        bit_op  = REQ.op == io_space_pkg::OP_BIT_SET ||
                  REQ.op == io_space_pkg::OP_BIT_CLR ||
                  REQ.op == io_space_pkg::OP_BIT_TEST;
        port_op = bit_op || REQ.op == io_space_pkg::OP_IO_READ ||
                  REQ.op == io_space_pkg::OP_IO_WRITE;
        mem_op  = REQ.op == io_space_pkg::OP_MEM_LOAD ||
                  REQ.op == io_space_pkg::OP_MEM_WRITE;
        mem_rel = REQ.addr - `DATA_OFFSET;                        // R8
        // Port forms only carry six bits, so they never reach 0x60 up
        io_idx  = port_op ? REQ.addr[5:0] : mem_rel[5:0];         // R7
        ext_hit = mem_op && REQ.addr >= `EXT_BASE;                // R9
        io_hit  = port_op ||
                  (mem_op && REQ.addr >= `DATA_OFFSET && !ext_hit);  // R8
        bit_ok  = io_idx <= `BIT_TOP;                             // R3
        wr_hit  = take && io_hit &&
                  (REQ.op == io_space_pkg::OP_IO_WRITE ||
                   REQ.op == io_space_pkg::OP_MEM_WRITE ||
                   ((REQ.op == io_space_pkg::OP_BIT_SET ||
                     REQ.op == io_space_pkg::OP_BIT_CLR) && bit_ok));  // R3
        wen = bit_op ? (8'h01 << REQ.bit_sel) : 8'hFF;           // R6
        if (REQ.op == io_space_pkg::OP_BIT_SET) begin
            wv = 8'hFF;
        end else if (REQ.op == io_space_pkg::OP_BIT_CLR) begin
            wv = 8'h00;
        end else begin
            wv = REQ.wdata;
        end
        if (io_idx == `A_PB_PIN) begin
            pin_val = pin_s2_r.b;
        end else if (io_idx == `A_PC_PIN) begin
            pin_val = pin_s2_r.c;
        end else if (io_idx == `A_PD_PIN) begin
            pin_val = pin_s2_r.d;
        end else begin
            pin_val = pin_s2_r.e;
        end
        rd_val = `M_NONE;
        if (io_hit) begin
            rd_val = (is_pin(io_idx) ? pin_val : IO_VIEW[io_idx])
                     & impl_mask(io_idx);                         // R10
        end
    end

    // ------------------------------------------------------------------
    // Register storage, one entry per I/O address
    // ------------------------------------------------------------------
    for (genvar i = 0; i <= `IO_TOP; i++) begin : g_reg
        logic [7:0] q_r;
        logic [7:0] q_nxt;
        logic [7:0] sel;
        logic [7:0] wm;
        logic [7:0] cm;
        logic [7:0] evt;

        always_comb begin
            // Pin addresses have no storage: their write mask stays zero
            wm  = is_pin(6'(i)) ? `M_NONE : impl_mask(6'(i));     // R10
            cm  = w1c_mask(6'(i));
            sel = (wr_hit && io_idx == 6'(i)) ? wen : 8'h00;      // R6
            if (6'(i) == `A_T0_FLAGS) begin
                evt = FLAG_EVT.t0;
            end else if (6'(i) == `A_T1_FLAGS) begin
                evt = FLAG_EVT.t1;
            end else if (6'(i) == `A_EXT_FLAGS) begin
                evt = FLAG_EVT.ei;
            end else if (6'(i) == `A_CMP_STAT) begin
                evt = FLAG_EVT.ac;
            end else begin
                evt = 8'h00;
            end
            q_nxt = (q_r & ~(sel & wm & ~cm)) | (wv & sel & wm & ~cm);  // R11
            q_nxt = q_nxt & ~(sel & wv & cm);                     // R5
            // Event in the clearing cycle is kept
            q_nxt = q_nxt | (evt & cm);
        end

        always_ff @(posedge CLOCK or posedge RST) begin
            if (RST) begin
                q_r <= 8'h00;
            end else begin
                q_r <= q_nxt;
            end
        end

        assign IO_VIEW[i] = q_r;
    end

    // ------------------------------------------------------------------
    // Answer and extended access
    // ------------------------------------------------------------------
    io_space_pkg::core_rsp_t rsp_r;
    io_space_pkg::core_rsp_t rsp_nxt;
    io_space_pkg::ext_req_t  ext_r;
    io_space_pkg::ext_req_t  ext_nxt;

    always_comb begin
        state_nxt = state_r;
        rsp_nxt   = '0;
        ext_nxt   = ext_r;
        case (state_r)
            io_space_pkg::S_IDLE: begin
                if (take && ext_hit) begin
                    ext_nxt.req   = 1'b1;                         // R9
                    ext_nxt.we    = REQ.op == io_space_pkg::OP_MEM_WRITE;
                    ext_nxt.addr  = REQ.addr;
                    ext_nxt.wdata = REQ.wdata;
                    state_nxt     = io_space_pkg::S_EXT_WAIT;
                end else if (take) begin
                    rsp_nxt.ack   = 1'b1;
                    rsp_nxt.rdata = rd_val;
                    // Skip tests only see the low 32 addresses
                    rsp_nxt.bit_val = bit_op && bit_ok && io_hit &&
                                      rd_val[REQ.bit_sel];        // R4
                end
            end
            io_space_pkg::S_EXT_WAIT: begin
                if (EXT_ACK) begin
                    ext_nxt.req   = 1'b0;
                    rsp_nxt.ack   = 1'b1;
                    rsp_nxt.rdata = ext_r.we ? 8'h00 : EXT_RDATA;
                    state_nxt     = io_space_pkg::S_IDLE;
                end
            end
            default: begin
                state_nxt   = io_space_pkg::S_IDLE;
                ext_nxt.req = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            state_r <= io_space_pkg::S_IDLE;
            rsp_r   <= '0;
            ext_r   <= '0;
        end else begin
            state_r <= state_nxt;
            rsp_r   <= rsp_nxt;
            ext_r   <= ext_nxt;
        end
    end

    assign BUSY    = state_r != io_space_pkg::S_IDLE;
    assign RSP     = rsp_r;
    assign EXT_OUT = ext_r;

endmodule : io_space_decode

/* io_space_decode_assertions.sv */
// Checker for the low I/O space decoder, seeing only its top ports.
// Assumes the io_space_pkg types and one clock with async reset.
`timescale 1ns/1ns
module io_space_checker (
    input wire logic                     CLOCK,
    input wire logic                     RST,
    input wire io_space_pkg::core_req_t  REQ,
    input wire logic                     BUSY,
    input wire io_space_pkg::core_rsp_t  RSP,
    input wire io_space_pkg::pin_level_t PIN_LEVEL,
    input wire io_space_pkg::flag_evt_t  FLAG_EVT,
    input wire io_space_pkg::ext_req_t   EXT_OUT,
    input wire logic                     EXT_ACK,
    input wire logic [7:0]               EXT_RDATA,
    input wire logic [63:0][7:0]         IO_VIEW
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    logic       take;
    logic       ext;
    logic       rw;
    logic [5:0] x;
    logic [7:0] bm;
    logic [7:0] cur;
    assign take = REQ.valid && !BUSY;
    assign ext  = REQ.op >= io_space_pkg::OP_MEM_LOAD && REQ.addr >= 8'h60;
    // I/O index is the data-space address less the offset
    assign x    = (REQ.op >= io_space_pkg::OP_MEM_LOAD) ? REQ.addr[5:0] - 6'h20 : REQ.addr[5:0];
    // Plain storage only, so flag events cannot disturb the compare
    assign rw   = x inside {6'h04, 6'h05, 6'h07, 6'h08, 6'h0A, 6'h0B, 6'h19, 6'h1A, 6'h1B, 6'h1E};
    assign bm   = 8'h01 << REQ.bit_sel;
    assign cur  = IO_VIEW[x];

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    a_int_answer: assert property (take && !ext |=> RSP.ack)
        else $error("internal access not answered next cycle");
    a_ext_start: assert property (take && ext |=> BUSY && EXT_OUT.req && EXT_OUT.addr == $past(REQ.addr))
        else $error("extended access not launched");
    a_ext_held: assert property (EXT_OUT.req && !EXT_ACK |=> EXT_OUT.req && $stable(EXT_OUT.addr) && !RSP.ack)
        else $error("extended request dropped early");
    a_ext_done: assert property (EXT_OUT.req && EXT_ACK |=> !BUSY && !EXT_OUT.req && RSP.ack
        && RSP.rdata == ($past(EXT_OUT.we) ? 8'h00 : $past(EXT_RDATA)))
        else $error("extended completion wrong");
    a_port_no_ext: assert property (take && REQ.op <= io_space_pkg::OP_BIT_TEST |=> !EXT_OUT.req)
        else $error("port instruction reached extended space");
    a_port_write: assert property (take && REQ.op == io_space_pkg::OP_IO_WRITE && rw
        |=> IO_VIEW[$past(x)] == $past(REQ.wdata))
        else $error("port write not stored");
    a_mem_map: assert property (take && REQ.op == io_space_pkg::OP_MEM_WRITE
        && REQ.addr inside {[8'h20:8'h5F]} && rw |=> IO_VIEW[$past(x)] == $past(REQ.wdata))
        else $error("data-space write misplaced");
    a_bit_set: assert property (take && REQ.op == io_space_pkg::OP_BIT_SET && rw
        |=> IO_VIEW[$past(x)] == ($past(cur) | $past(bm)))
        else $error("bit set wrong");
    a_bit_clear: assert property (take && REQ.op == io_space_pkg::OP_BIT_CLR && rw
        |=> IO_VIEW[$past(x)] == ($past(cur) & ~$past(bm)))
        else $error("bit clear wrong");
    a_bit_test: assert property (take && REQ.op == io_space_pkg::OP_BIT_TEST && rw
        |=> RSP.bit_val == $past(|(cur & bm)))
        else $error("bit test value wrong");
    a_high_bitop: assert property (take && REQ.op inside {io_space_pkg::OP_BIT_SET,
        io_space_pkg::OP_BIT_CLR} && x > 6'h1F |=> IO_VIEW[$past(x)] == $past(cur))
        else $error("bit op above range changed a register");
    a_flag_w1c: assert property (take && REQ.op == io_space_pkg::OP_IO_WRITE && x == 6'h1C
        && FLAG_EVT.ei == 8'h00 |=> IO_VIEW[6'h1C] == ($past(cur) & ~$past(REQ.wdata)))
        else $error("flag clear wrong");

    c_ext: cover property (take && ext);
    c_bit_set: cover property (take && REQ.op == io_space_pkg::OP_BIT_SET && rw);
    c_ext_ack: cover property (EXT_OUT.req && EXT_ACK);
endmodule : io_space_checker

bind io_space_decode io_space_checker chk_u (.CLOCK(CLOCK), .RST(RST), .REQ(REQ), .BUSY(BUSY),
    .RSP(RSP), .PIN_LEVEL(PIN_LEVEL), .FLAG_EVT(FLAG_EVT), .EXT_OUT(EXT_OUT),
    .EXT_ACK(EXT_ACK), .EXT_RDATA(EXT_RDATA), .IO_VIEW(IO_VIEW));

/* ext_space_model.sv */
// Extended register space behind the decoder, with adjustable wait.
// Assumes requests held until acknowledged, one at a time.
`timescale 1ns/1ns
module ext_space_model (
    input  wire logic                   clock,
    input  wire logic                   rst,
    input  wire io_space_pkg::ext_req_t ext_out,
    input  wire logic [3:0]             delay,
    output logic                        ext_ack,
    output logic [7:0]                  ext_rdata
);
    // ------------------------------------------------------------
    // Storage and answer
    // ------------------------------------------------------------
    logic [7:0] mem_r [256];
    logic [3:0] wait_r;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ext_ack <= 1'b0;
            ext_rdata <= 8'h00;
            wait_r <= 4'h0;
        end else begin
            ext_ack <= 1'b0;
            // Idle data toggles so a stale read cannot pass
            ext_rdata <= ~ext_rdata;
            if (ext_out.req && !ext_ack) begin
                if (wait_r >= delay) begin
                    ext_ack <= 1'b1;
                    wait_r <= 4'h0;
                    ext_rdata <= mem_r[ext_out.addr];
                    if (ext_out.we) begin
                        mem_r[ext_out.addr] <= ext_out.wdata;
                    end
                end else begin
                    wait_r <= wait_r + 4'h1;
                end
            end
        end
    end
endmodule : ext_space_model

/* tb.sv */
// Self-checking bench for the low I/O space decoder.
// Assumes the extended space model answers the decoder's far side.
`timescale 1ns/1ns
module tb;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic                     CLOCK = 1'b0;
    logic                     RST = 1'b1;
    io_space_pkg::core_req_t  REQ = '0;
    io_space_pkg::pin_level_t PIN_LEVEL = '0;
    io_space_pkg::flag_evt_t  FLAG_EVT = '0;
    logic                     BUSY;
    io_space_pkg::core_rsp_t  RSP;
    io_space_pkg::ext_req_t   EXT_OUT;
    logic                     EXT_ACK;
    logic [7:0]               EXT_RDATA;
    logic [63:0][7:0]         IO_VIEW;
    logic [3:0]               ext_delay = 4'h0;
    logic [7:0]               rd;
    logic                     bv;
    logic [7:0]               e;
    int                       n_errors = 0;
    int                       n_compared = 0;
    logic [7:0] rw_list [14] = '{8'h04, 8'h05, 8'h07, 8'h08, 8'h0A, 8'h0B, 8'h19,
                                 8'h1A, 8'h1B, 8'h1E, 8'h20, 8'h21, 8'h27, 8'h2E};
    logic [7:0] res_list [10] = '{8'h00, 8'h01, 8'h02, 8'h0F, 8'h10, 8'h14, 8'h17,
                                  8'h18, 8'h2B, 8'h3C};
    logic [7:0] ext_list [3] = '{8'h60, 8'h69, 8'hFF};

    always #20 CLOCK = ~CLOCK;

    io_space_decode dut_u (.CLOCK(CLOCK), .RST(RST), .REQ(REQ), .BUSY(BUSY), .RSP(RSP),
        .PIN_LEVEL(PIN_LEVEL), .FLAG_EVT(FLAG_EVT), .EXT_OUT(EXT_OUT), .EXT_ACK(EXT_ACK),
        .EXT_RDATA(EXT_RDATA), .IO_VIEW(IO_VIEW));
    ext_space_model ext_u (.clock(CLOCK), .rst(RST), .ext_out(EXT_OUT), .delay(ext_delay),
        .ext_ack(EXT_ACK), .ext_rdata(EXT_RDATA));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // One core request, held until taken, then wait for the answer
    task automatic acc(input logic [2:0] op, input logic [7:0] a, input logic [2:0] b,
                       input logic [7:0] wd);
        int n;
        n = 0;
        REQ <= {1'b1, io_space_pkg::op_t'(op), a, b, wd};
        @(posedge CLOCK);
        while (BUSY !== 1'b0 && n < 50) begin
            @(posedge CLOCK);
            n++;
        end
        REQ <= '0;
        n = 0;
        do begin
            @(posedge CLOCK);
            n++;
        end while (RSP.ack !== 1'b1 && n < 50);
        rd = RSP.rdata;
        bv = RSP.bit_val;
        chk("ack", {7'h00, RSP.ack}, 8'h01);
    endtask : acc

    task automatic end_of_test;
        if (n_errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge CLOCK);
        RST <= 1'b0;
        @(posedge CLOCK);
        foreach (rw_list[i]) begin
            e = rw_list[i] ^ 8'h5A;
            acc(3'h0, rw_list[i], 3'h0, 8'h00);
            chk("reset", rd, 8'h00);
            acc(3'h1, rw_list[i] | 8'hC0, 3'h0, e);
            acc(3'h5, rw_list[i] + 8'h20, 3'h0, 8'h00);
            chk("mem read", rd, e);
            acc(3'h6, rw_list[i] + 8'h20, 3'h0, ~e);
            acc(3'h0, rw_list[i], 3'h0, 8'h00);
            chk("mem write", rd, ~e);
        end
        foreach (res_list[i]) begin
            acc(3'h0, res_list[i], 3'h0, 8'h00);
            chk("reserved", rd, 8'h00);
        end
        // Pins pass a two-flop synchroniser before they are readable
        PIN_LEVEL <= {8'h3C, 8'hA5, 8'h96, 8'hFF};
        repeat (3) @(posedge CLOCK);
        acc(3'h0, 8'h03, 3'h0, 8'h00);
        chk("pins b", rd, 8'h3C);
        acc(3'h0, 8'h0C, 3'h0, 8'h00);
        chk("pins e", rd, 8'h07);
        for (int k = 0; k < 8; k++) begin
            acc(3'h4, 8'h09, k[2:0], 8'h00);
            chk("bit test", {7'h00, bv}, (8'h96 >> k) & 8'h01);
        end
        acc(3'h1, 8'h19, 3'h0, 8'h00);
        e = 8'h00;
        for (int k = 7; k >= 0; k--) begin
            acc(3'h2, 8'h19, k[2:0], 8'h00);
            e = e | (8'h01 << k);
            acc(3'h0, 8'h19, 3'h0, 8'h00);
            chk("bit set", rd, e);
        end
        acc(3'h3, 8'h19, 3'h3, 8'h00);
        acc(3'h0, 8'h19, 3'h0, 8'h00);
        chk("bit clear", rd, 8'hF7);
        acc(3'h4, 8'h19, 3'h7, 8'h00);
        chk("bit test rw", {7'h00, bv}, 8'h01);
        acc(3'h5, 8'h19, 3'h0, 8'h00);
        chk("mem below map", rd, 8'h00);
        acc(3'h1, 8'h20, 3'h0, 8'h11);
        acc(3'h2, 8'h20, 3'h1, 8'h00);
        acc(3'h0, 8'h20, 3'h0, 8'h00);
        chk("bit op above range", rd, 8'h11);
        FLAG_EVT <= {8'h00, 8'h00, 8'h0F, 8'h70};
        @(posedge CLOCK);
        FLAG_EVT <= '0;
        acc(3'h1, 8'h1C, 3'h0, 8'h00);
        acc(3'h0, 8'h1C, 3'h0, 8'h00);
        chk("flag zero write", rd, 8'h0F);
        acc(3'h3, 8'h1C, 3'h1, 8'h00);
        acc(3'h0, 8'h1C, 3'h0, 8'h00);
        chk("flag bit clear op", rd, 8'h0F);
        acc(3'h2, 8'h1C, 3'h0, 8'h00);
        acc(3'h0, 8'h1C, 3'h0, 8'h00);
        chk("flag bit set op", rd, 8'h0E);
        acc(3'h1, 8'h1C, 3'h0, 8'h04);
        acc(3'h0, 8'h1C, 3'h0, 8'h00);
        chk("flag one write", rd, 8'h0A);
        acc(3'h1, 8'h30, 3'h0, 8'h10);
        acc(3'h0, 8'h70, 3'h0, 8'h00);
        chk("port read 0x70", rd, 8'h60);
        // Slow and prompt far side both exercised
        foreach (ext_list[i]) begin
            ext_delay <= 4'(i * 3);
            acc(3'h6, ext_list[i], 3'h0, ext_list[i] ^ 8'h3C);
            chk("ext write", rd, 8'h00);
            acc(3'h5, ext_list[i], 3'h0, 8'h00);
            chk("ext read", rd, ext_list[i] ^ 8'h3C);
        end
        acc(3'h5, 8'h5F, 3'h0, 8'h00);
        chk("top of internal", rd, 8'h00);
        end_of_test();
    end

    initial begin
        repeat (20000) @(posedge CLOCK);
        n_errors = n_errors + 1;
        end_of_test();
    end
endmodule : tb
